// ---- hdl/fdcaux_top.sv ----
// command interpreter for the floppy controller's positioning and setup commands
//
// Overview of operation
// - recalibrate steps the chosen drive outward until track zero shows or 80 steps have been issued, then raises interrupt.
// - sense interrupt status takes no parameters and returns status byte zero then the cylinder.
// - seek moves the chosen drive's head to the new cylinder number with no data transferred.
// - register dump returns ten bytes: four cylinders, then timing, count, lock and config.
// - sense drive status answers with one byte describing the addressed drive.
module fdcaux_top #(
    parameter int STEP_UNIT_CYCLES = fdcaux_pkg::STEP_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic rd_strobe,
    input wire logic track_zero,
    input wire logic write_protect,
    input wire logic drive_ready,
    input wire logic two_sided,
    output logic [7:0] rd_data,
    output logic write_ready,
    output logic result_ready,
    output logic busy,
    output logic int_pending,
    output logic [1:0] drive_sel,
    output logic head_select,
    output logic step,
    output logic step_inward,
    output fdcaux_pkg::fdcaux_cfg_t cfg
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    fdcaux_pkg::fdcaux_state_t state_reg, state_next;
    fdcaux_pkg::fdcaux_cfg_t cfg_reg, cfg_next;
    logic [7:0] opcode_reg, opcode_next;
    logic [7:0] par_reg [0:4];
    logic [7:0] par_next [0:4];
    logic [2:0] par_cnt_reg, par_cnt_next;
    logic [2:0] par_need_reg, par_need_next;
    logic [7:0] res_reg [0:9];
    logic [7:0] res_next [0:9];
    logic [3:0] res_cnt_reg, res_cnt_next;
    logic [3:0] res_idx_reg, res_idx_next;
    logic [7:0] present_cylinder_number_reg [0:3];
    logic [7:0] present_cylinder_number_next [0:3];
    logic [7:0] status_byte_zero_reg, status_byte_zero_next;
    logic [7:0] sectors_per_cylinder_reg, sectors_per_cylinder_next;
    logic int_reg, int_next;
    logic [1:0] sel_reg, sel_next;
    logic head_reg, head_next;
    logic [7:0] target_reg, target_next;
    logic recal_reg, recal_next;
    logic [7:0] steps_reg, steps_next;
    logic [19:0] tick_reg, tick_next;
    logic step_reg, step_next;
    logic dir_reg, dir_next;
    logic [9:0] fmt_left_reg, fmt_left_next;
    logic [7:0] rd_data_reg, rd_data_next;

    // decode helpers
    logic go;
    logic [7:0] cmd;
    logic [2:0] need;
    logic valid_cmd;
    logic [19:0] period;
    logic [7:0] cur_cyl;
    logic [8:0] rel_sum;
    logic arrive;

    // step period widens as the rate code shrinks, one unit per slot
    assign period = 20'((fdcaux_pkg::STEP_SLOTS - int'(cfg_reg.step_rate_time)) *
                        STEP_UNIT_CYCLES);
    assign cur_cyl = present_cylinder_number_reg[sel_reg];

    // parameter count of a fresh command byte; unknown bytes flag invalid
    always_comb begin
        valid_cmd = 1'b1;
        need = fdcaux_pkg::NPAR_NONE;
        if ((wr_data & fdcaux_pkg::MASK_D6) == fdcaux_pkg::CMD_FORMAT) begin
            need = fdcaux_pkg::NPAR_FORMAT;
        end else if (wr_data == fdcaux_pkg::CMD_RECAL || wr_data == fdcaux_pkg::CMD_PERP ||
                     wr_data == fdcaux_pkg::CMD_SENSE_DRIVE) begin
            need = fdcaux_pkg::NPAR_ONE;
        end else if (wr_data == fdcaux_pkg::CMD_SPECIFY || wr_data == fdcaux_pkg::CMD_SEEK ||
                     (wr_data & fdcaux_pkg::MASK_D6) == fdcaux_pkg::CMD_REL_SEEK) begin
            need = fdcaux_pkg::NPAR_TWO;
        end else if (wr_data == fdcaux_pkg::CMD_CONFIGURE) begin
            need = fdcaux_pkg::NPAR_CONFIGURE;
        end else if (!(wr_data == fdcaux_pkg::CMD_SENSE_INT || wr_data == fdcaux_pkg::CMD_DUMP ||
                       (wr_data & fdcaux_pkg::MASK_D7) == fdcaux_pkg::CMD_LOCK)) begin
            valid_cmd = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic for the whole interpreter
    always_comb begin
        state_next = state_reg;
        cfg_next = cfg_reg;
        opcode_next = opcode_reg;
        par_next = par_reg;
        par_cnt_next = par_cnt_reg;
        par_need_next = par_need_reg;
        res_next = res_reg;
        res_cnt_next = res_cnt_reg;
        res_idx_next = res_idx_reg;
        present_cylinder_number_next = present_cylinder_number_reg;
        status_byte_zero_next = status_byte_zero_reg;
        sectors_per_cylinder_next = sectors_per_cylinder_reg;
        int_next = int_reg;
        sel_next = sel_reg;
        head_next = head_reg;
        target_next = target_reg;
        recal_next = recal_reg;
        steps_next = steps_reg;
        tick_next = tick_reg;
        step_next = 1'b0;
        dir_next = dir_reg;
        fmt_left_next = fmt_left_reg;
        go = 1'b0;
        cmd = opcode_reg;
        rel_sum = 9'h000;
        arrive = 1'b0;
        case (state_reg)
            fdcaux_pkg::S_IDLE: begin
                if (wr_strobe) begin
                    opcode_next = wr_data;
                    par_cnt_next = 3'h0;
                    par_need_next = need;
                    res_idx_next = 4'h0;
                    if (!valid_cmd) begin
                        res_next[0] = fdcaux_pkg::STAT_INVALID;
                        res_cnt_next = fdcaux_pkg::RES_ONE;
                        state_next = fdcaux_pkg::S_RESULT;
                    end else if (need == fdcaux_pkg::NPAR_NONE) begin
                        go = 1'b1;
                        cmd = wr_data;
                    end else begin
                        state_next = fdcaux_pkg::S_PARAM;
                    end
                end
            end
            fdcaux_pkg::S_PARAM: begin
                if (wr_strobe) begin
                    par_next[par_cnt_reg] = wr_data;
                    par_cnt_next = par_cnt_reg + 3'h1;
                    if (par_cnt_reg + 3'h1 == par_need_reg) begin
                        go = 1'b1;
                    end
                end
            end
            fdcaux_pkg::S_FORMAT: begin
                // identity bytes are counted only; no track image is built here
                if (wr_strobe) begin
                    fmt_left_next = fmt_left_reg - 10'h001;
                    if (fmt_left_reg == 10'h001) begin
                        state_next = fdcaux_pkg::S_RESULT;
                    end
                end
            end
            fdcaux_pkg::S_MOVE: begin
                // one decision per step period, so the rate setting paces motion
                if (tick_reg + 20'h00001 >= period) begin
                    tick_next = 20'h00000;
                    arrive = recal_reg ? track_zero : (cur_cyl == target_reg);
                    if (arrive) begin
                        if (recal_reg) begin
                            present_cylinder_number_next[sel_reg] = 8'h00;
                        end
                        status_byte_zero_next = fdcaux_pkg::STAT_SEEK_END |
                            {5'h00, head_reg, sel_reg};
                        int_next = 1'b1;
                        state_next = fdcaux_pkg::S_IDLE;
                    end else if (recal_reg && steps_reg == fdcaux_pkg::STEP_LIMIT) begin
                        // a drive that never shows track zero must not hang the block
                        status_byte_zero_next = fdcaux_pkg::STAT_RECAL_FAIL | {6'h00, sel_reg};
                        int_next = 1'b1;
                        state_next = fdcaux_pkg::S_IDLE;
                    end else begin
                        step_next = 1'b1;
                        steps_next = steps_reg + 8'h01;
                        present_cylinder_number_next[sel_reg] = dir_reg ? cur_cyl + 8'h01 :
                                                                          cur_cyl - 8'h01;
                    end
                end else begin
                    tick_next = tick_reg + 20'h00001;
                end
            end
            fdcaux_pkg::S_RESULT: begin
                if (rd_strobe) begin
                    res_idx_next = res_idx_reg + 4'h1;
                    if (res_idx_reg + 4'h1 == res_cnt_reg) begin
                        res_idx_next = 4'h0;
                        state_next = fdcaux_pkg::S_IDLE;
                    end
                end
            end
            default: begin
                state_next = fdcaux_pkg::S_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////////
        // execution once the last parameter byte is in, or on the opening byte of a command with no parameters
        if (go) begin
            state_next = fdcaux_pkg::S_IDLE;
            if ((cmd & fdcaux_pkg::MASK_D6) == fdcaux_pkg::CMD_FORMAT) begin
                sel_next = par_next[0][1:0];
                head_next = par_next[0][2];
                sectors_per_cylinder_next = par_next[2];
                fmt_left_next = {par_next[2], 2'b00};
                res_next[0] = {5'h00, par_next[0][2:0]};
                for (int i = 1; i < 7; i++) begin
                    res_next[i] = 8'h00;
                end
                res_cnt_next = fdcaux_pkg::RES_FORMAT;
                state_next = (par_next[2] == 8'h00) ? fdcaux_pkg::S_RESULT :
                                                     fdcaux_pkg::S_FORMAT;
            end else if (cmd == fdcaux_pkg::CMD_RECAL) begin
                sel_next = par_next[0][1:0];
                head_next = 1'b0;
                recal_next = 1'b1;
                dir_next = 1'b0;
                steps_next = 8'h00;
                tick_next = 20'h00000;
                state_next = fdcaux_pkg::S_MOVE;
            end else if (cmd == fdcaux_pkg::CMD_SEEK ||
                         (cmd & fdcaux_pkg::MASK_D6) == fdcaux_pkg::CMD_REL_SEEK) begin
                sel_next = par_next[0][1:0];
                head_next = par_next[0][2];
                recal_next = 1'b0;
                steps_next = 8'h00;
                tick_next = 20'h00000;
                target_next = par_next[1];
                if (cmd[7]) begin
                    // relative moves clamp at the ends of the cylinder range
                    rel_sum = {1'b0, present_cylinder_number_reg[par_next[0][1:0]]};
                    if (cmd[6]) begin
                        rel_sum = rel_sum + {1'b0, par_next[1]};
                        target_next = rel_sum[8] ? 8'hFF : rel_sum[7:0];
                    end else begin
                        target_next = (par_next[1] > rel_sum[7:0]) ? 8'h00 :
                                      rel_sum[7:0] - par_next[1];
                    end
                end
                // direction fixed before the first pulse so it never changes with step high
                dir_next = target_next > present_cylinder_number_reg[par_next[0][1:0]];
                state_next = fdcaux_pkg::S_MOVE;
            end else if (cmd == fdcaux_pkg::CMD_SENSE_INT) begin
                res_next[0] = int_reg ? status_byte_zero_reg : fdcaux_pkg::STAT_INVALID;
                res_next[1] = present_cylinder_number_reg[status_byte_zero_reg[1:0]];
                res_cnt_next = fdcaux_pkg::RES_SENSE_INT;
                int_next = 1'b0;
                state_next = fdcaux_pkg::S_RESULT;
            end else if (cmd == fdcaux_pkg::CMD_SPECIFY) begin
                cfg_next.step_rate_time = par_next[0][7:4];
                cfg_next.head_unload_time = par_next[0][3:0];
                cfg_next.head_load_time = par_next[1][7:1];
                cfg_next.non_dma_flag = par_next[1][0];
            end else if (cmd == fdcaux_pkg::CMD_CONFIGURE) begin
                cfg_next.implied_seek_enable = par_next[1][6];
                cfg_next.fifo_disable_flag = par_next[1][5];
                cfg_next.poll_disable = par_next[1][4];
                cfg_next.fifo_threshold = par_next[1][3:0];
                cfg_next.precomp_start_track = par_next[2];
            end else if (cmd == fdcaux_pkg::CMD_DUMP) begin
                for (int d = 0; d < 4; d++) begin
                    res_next[d] = present_cylinder_number_reg[d];
                end
                res_next[4] = {cfg_reg.step_rate_time, cfg_reg.head_unload_time};
                res_next[5] = {cfg_reg.head_load_time, cfg_reg.non_dma_flag};
                res_next[6] = sectors_per_cylinder_reg;
                res_next[7] = {cfg_reg.lock, 1'b0, cfg_reg.perp_drives, cfg_reg.perp_gap,
                               cfg_reg.write_gate_perp};
                res_next[8] = {1'b0, cfg_reg.implied_seek_enable, cfg_reg.fifo_disable_flag,
                               cfg_reg.poll_disable, cfg_reg.fifo_threshold};
                res_next[9] = cfg_reg.precomp_start_track;
                res_cnt_next = fdcaux_pkg::RES_DEPTH;
                state_next = fdcaux_pkg::S_RESULT;
            end else if (cmd == fdcaux_pkg::CMD_PERP) begin
                if (par_next[0][7]) begin
                    cfg_next.perp_drives = par_next[0][5:2];
                end
                cfg_next.perp_gap = par_next[0][1];
                cfg_next.write_gate_perp = par_next[0][0];
            end else if ((cmd & fdcaux_pkg::MASK_D7) == fdcaux_pkg::CMD_LOCK) begin
                cfg_next.lock = cmd[7];
                res_next[0] = {3'h0, cmd[7], 4'h0};
                res_cnt_next = fdcaux_pkg::RES_ONE;
                state_next = fdcaux_pkg::S_RESULT;
            end else begin
                // sense drive status reads the live drive lines
                sel_next = par_next[0][1:0];
                head_next = par_next[0][2];
                res_next[0] = {1'b0, write_protect, drive_ready, track_zero, two_sided,
                               par_next[0][2:0]};
                res_cnt_next = fdcaux_pkg::RES_ONE;
                state_next = fdcaux_pkg::S_RESULT;
            end
        end
        // the read port always shows the byte the next read strobe would take
        rd_data_next = res_next[res_idx_next];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= fdcaux_pkg::S_IDLE;
            cfg_reg <= fdcaux_pkg::CFG_RESET;
            opcode_reg <= 8'h00;
            par_reg <= '{default: 8'h00};
            par_cnt_reg <= 3'h0;
            par_need_reg <= 3'h0;
            res_reg <= '{default: 8'h00};
            res_cnt_reg <= 4'h0;
            res_idx_reg <= 4'h0;
            present_cylinder_number_reg <= '{default: 8'h00};
            status_byte_zero_reg <= 8'h00;
            sectors_per_cylinder_reg <= 8'h00;
            int_reg <= 1'b0;
            sel_reg <= 2'h0;
            head_reg <= 1'b0;
            target_reg <= 8'h00;
            recal_reg <= 1'b0;
            steps_reg <= 8'h00;
            tick_reg <= 20'h00000;
            step_reg <= 1'b0;
            dir_reg <= 1'b0;
            fmt_left_reg <= 10'h000;
            rd_data_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
            opcode_reg <= opcode_next;
            par_reg <= par_next;
            par_cnt_reg <= par_cnt_next;
            par_need_reg <= par_need_next;
            res_reg <= res_next;
            res_cnt_reg <= res_cnt_next;
            res_idx_reg <= res_idx_next;
            present_cylinder_number_reg <= present_cylinder_number_next;
            status_byte_zero_reg <= status_byte_zero_next;
            sectors_per_cylinder_reg <= sectors_per_cylinder_next;
            int_reg <= int_next;
            sel_reg <= sel_next;
            head_reg <= head_next;
            target_reg <= target_next;
            recal_reg <= recal_next;
            steps_reg <= steps_next;
            tick_reg <= tick_next;
            step_reg <= step_next;
            dir_reg <= dir_next;
            fmt_left_reg <= fmt_left_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // outputs straight from flops, except write_ready, result_ready and busy, which are decoded from state_reg
    assign rd_data = rd_data_reg;
    assign write_ready = (state_reg == fdcaux_pkg::S_IDLE) || (state_reg == fdcaux_pkg::S_PARAM) ||
                         (state_reg == fdcaux_pkg::S_FORMAT);
    assign result_ready = (state_reg == fdcaux_pkg::S_RESULT);
    assign busy = (state_reg != fdcaux_pkg::S_IDLE);
    assign int_pending = int_reg;
    assign drive_sel = sel_reg;
    assign head_select = head_reg;
    assign step = step_reg;
    assign step_inward = dir_reg;
    assign cfg = cfg_reg;

endmodule

// ---- pkg/fdcaux_pkg.sv ----
// constants, types and command codes shared by the auxiliary command interpreter
package fdcaux_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int STEP_UNIT_NS = 1000000;
    // least time, so round up
    localparam int STEP_UNIT_CYCLES = (STEP_UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STEP_SLOTS = 16;
    localparam logic [7:0] STEP_LIMIT = 8'h50;

    ////////////////////////////////////////////////////////////////////////////////
    // command bytes, compared after masking the option bits
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_D6 = 8'hBF;
    localparam logic [7:0] MASK_D7 = 8'h7F;
    localparam logic [7:0] CMD_FORMAT = 8'h0D;
    localparam logic [7:0] CMD_RECAL = 8'h07;
    localparam logic [7:0] CMD_SENSE_INT = 8'h08;
    localparam logic [7:0] CMD_SPECIFY = 8'h03;
    localparam logic [7:0] CMD_SEEK = 8'h0F;
    localparam logic [7:0] CMD_CONFIGURE = 8'h13;
    localparam logic [7:0] CMD_REL_SEEK = 8'h8F;
    localparam logic [7:0] CMD_DUMP = 8'h0E;
    localparam logic [7:0] CMD_PERP = 8'h12;
    localparam logic [7:0] CMD_LOCK = 8'h14;
    localparam logic [7:0] CMD_SENSE_DRIVE = 8'h04;

    // parameter byte counts per command
    localparam logic [2:0] NPAR_FORMAT = 3'h5;
    localparam logic [2:0] NPAR_ONE = 3'h1;
    localparam logic [2:0] NPAR_TWO = 3'h2;
    localparam logic [2:0] NPAR_CONFIGURE = 3'h3;
    localparam logic [2:0] NPAR_NONE = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // result values and counts
    localparam logic [7:0] STAT_INVALID = 8'h80;
    localparam logic [7:0] STAT_SEEK_END = 8'h20;
    localparam logic [7:0] STAT_RECAL_FAIL = 8'h70;
    localparam logic [3:0] RES_DEPTH = 4'hA;
    localparam logic [3:0] RES_FORMAT = 4'h7;
    localparam logic [3:0] RES_SENSE_INT = 4'h2;
    localparam logic [3:0] RES_ONE = 4'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_PARAM = 5'b00010,
        S_FORMAT = 5'b00100,
        S_MOVE = 5'b01000,
        S_RESULT = 5'b10000
    } fdcaux_state_t;

    typedef struct packed {
        logic [3:0] step_rate_time;
        logic [3:0] head_unload_time;
        logic [6:0] head_load_time;
        logic non_dma_flag;
        logic implied_seek_enable;
        logic fifo_disable_flag;
        logic poll_disable;
        logic [3:0] fifo_threshold;
        logic [7:0] precomp_start_track;
        logic lock;
        logic [3:0] perp_drives;
        logic perp_gap;
        logic write_gate_perp;
    } fdcaux_cfg_t;

    localparam fdcaux_cfg_t CFG_RESET = '{
        step_rate_time: 4'h0, head_unload_time: 4'h0, head_load_time: 7'h00,
        non_dma_flag: 1'b0, implied_seek_enable: 1'b0, fifo_disable_flag: 1'b1,
        poll_disable: 1'b0, fifo_threshold: 4'h0, precomp_start_track: 8'h00,
        lock: 1'b0, perp_drives: 4'h0, perp_gap: 1'b0, write_gate_perp: 1'b0};

endpackage

// ---- sim/fdcaux_chk.sv ----
// checker: port-level properties of the auxiliary command interpreter
module fdcaux_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic write_ready,
    input wire logic result_ready,
    input wire logic busy,
    input wire logic int_pending,
    input wire logic step,
    input wire logic step_inward,
    input wire logic track_zero
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cmd_reg;
    logic [7:0] par_reg;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // remember the opening byte and the latest byte of a command
    always_ff @(posedge clock) begin
        if (wr_strobe && write_ready) begin
            par_reg <= wr_data;
            if (!busy) begin
                cmd_reg <= wr_data;
            end
        end
    end
    AST_RECAL_OUT: assert property (step && !step_inward |-> !track_zero)
        else $error("outward step at track zero");
    AST_MOVE_END: assert property ($rose(int_pending) |-> ##[0:1] !busy)
        else $error("move end did not return to standby");
    AST_SENSE_INT: assert property (wr_strobe && !busy && wr_data == 8'h08 |=>
        result_ready)
        else $error("sense interrupt gave no result");
    AST_STEP_PULSE: assert property (step |=> !step)
        else $error("step longer than one cycle");
    AST_DIR_HOLD: assert property (step |-> $stable(step_inward))
        else $error("direction moved with the step");
    AST_DUMP: assert property (wr_strobe && !busy && wr_data == 8'h0E |=> result_ready)
        else $error("dump gave no result");
    AST_DRIVE_STATUS: assert property ($rose(result_ready) && cmd_reg == 8'h04 |->
        rd_data[2:0] == par_reg[2:0] && !rd_data[7])
        else $error("drive status byte does not match request");
    AST_INVALID: assert property (wr_strobe && !busy && wr_data == 8'h00 |=>
        result_ready && rd_data == 8'h80)
        else $error("undefined code not answered with 80");
    cover property ($rose(int_pending));
    cover property (step && !step_inward);
    cover property ($rose(result_ready));
endmodule
bind fdcaux_top fdcaux_chk chk_u (.clock(clock), .rst_n(rst_n), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .rd_data(rd_data), .write_ready(write_ready), .busy(busy),
    .result_ready(result_ready), .int_pending(int_pending), .step(step),
    .step_inward(step_inward), .track_zero(track_zero));

// ---- sim/fdcaux_host.sv ----
// host model: writes command bytes and reads result bytes
module fdcaux_host (
    input wire logic clock,
    input wire logic write_ready,
    input wire logic result_ready,
    input wire logic [7:0] rd_data,
    output logic wr_strobe,
    output logic [7:0] wr_data,
    output logic rd_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_data = 8'h00;
    end
    // idle data is inverted so a stale byte never looks fresh
    task automatic put(input logic [7:0] b);
        @(negedge clock);
        for (int n = 0; n < 100 && !write_ready; n++) @(negedge clock);
        wr_data = b;
        wr_strobe = 1'b1;
        @(negedge clock);
        wr_strobe = 1'b0;
        wr_data = ~b;
    endtask
    // results are taken in order, one per read pulse
    task automatic get(output logic [7:0] b);
        @(negedge clock);
        for (int n = 0; n < 100 && !result_ready; n++) @(negedge clock);
        b = rd_data;
        rd_strobe = 1'b1;
        @(negedge clock);
        rd_strobe = 1'b0;
    endtask
endmodule

// ---- sim/tb.sv ----
// testbench: command sequences compared with a reference model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
    logic clock, rst_n, wr_strobe, rd_strobe, write_ready, result_ready, busy, int_pending;
    logic track_zero, write_protect, drive_ready, two_sided, head_select, step, step_inward;
    logic [7:0] wr_data, rd_data;
    logic [1:0] drive_sel;
    fdcaux_pkg::fdcaux_cfg_t cfg;
    logic [7:0] q[$];
    int present_cylinder_number[4];
    int fails, num_checks, seed, drive_cyl;
    fdcaux_top #(.STEP_UNIT_CYCLES(2)) dut_u (.clock(clock), .rst_n(rst_n),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
        .track_zero(track_zero), .write_protect(write_protect), .drive_ready(drive_ready),
        .two_sided(two_sided), .rd_data(rd_data), .write_ready(write_ready),
        .result_ready(result_ready), .busy(busy), .int_pending(int_pending),
        .drive_sel(drive_sel), .head_select(head_select), .step(step),
        .step_inward(step_inward), .cfg(cfg));
    fdcaux_host host_u (.clock(clock), .write_ready(write_ready), .result_ready(result_ready),
        .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe));
    // drive head model; starts off track zero so a recalibrate must really step
    initial drive_cyl = 3;
    always @(posedge clock) if (step) drive_cyl <= step_inward ? drive_cyl + 1 : drive_cyl - 1;
    assign track_zero = (drive_cyl == 0);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic send(input logic [7:0] s[$]);
        foreach (s[i]) host_u.put(s[i]);
    endtask
    task automatic drain(input string nm);
        logic [7:0] b, e;
        while (q.size() > 0) begin
            host_u.get(b);
            e = q.pop_front();
            `CHK(nm, e, b)
        end
        `CHK("result_ready", 1'b0, result_ready)
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 4000 && busy; n++) @(negedge clock);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a hang is cut short well past the expected run length
    initial begin
        #(50 * 60000);
        fails++;
        final_report();
    end
    initial begin
        logic [7:0] a, b, c, d, h, t;
        seed = 32'hEC0F947D;
        {rst_n, write_protect, drive_ready, two_sided} = 4'h0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        q.push_back(8'h80);
        send('{8'h00});
        drain("invalid");
        a = {4'hF, 4'($random(seed))};
        b = 8'($random(seed));
        send('{8'h03, a, b});
        d = 8'($random(seed)) & 8'h03;
        send('{8'h07, d});
        wait_idle();
        `CHK("track", 0, drive_cyl)
        `CHK("int", 1'b1, int_pending)
        q = '{8'h20 | d, 8'h00};
        send('{8'h08});
        drain("sense int recal");
        h = 8'($random(seed)) & 8'h01;
        t = 8'(1 + ($random(seed) & 5));
        send('{8'h0F, (h << 2) | d, t});
        wait_idle();
        `CHK("cylinder", t, 8'(drive_cyl))
        present_cylinder_number[d] = t;
        q = '{8'h20 | (h << 2) | d, t};
        send('{8'h08});
        drain("sense int seek");
        for (int i = 0; i < 4; i++) begin
            {write_protect, drive_ready, two_sided} = 3'($random(seed));
            q.push_back({1'b0, write_protect, drive_ready, track_zero, two_sided, h[0], 2'(i)});
            send('{8'h04, (h << 2) | 8'(i)});
            drain("drive status");
            `CHK("sel", {h[0], 2'(i)}, {head_select, drive_sel})
        end
        q = '{(h << 2) | d, 0, 0, 0, 0, 0, 0};
        send('{8'h0D, (h << 2) | d, 8'h02, 8'h02, 8'h1B, 8'hE5});
        for (int i = 0; i < 8; i++) host_u.put(8'($random(seed)));
        drain("format");
        send('{8'hCF, (h << 2) | d, 8'h02});
        wait_idle();
        present_cylinder_number[d] = t + 2;
        `CHK("rel seek", present_cylinder_number[d], drive_cyl)
        c = 8'($random(seed));
        send('{8'h13, 8'h00, c & 8'h7F, c});
        q = '{8'h10};
        send('{8'h12, 8'hFF, 8'h94});
        drain("lock");
        `CHK("lock", 1'b1, cfg.lock)
        q = '{present_cylinder_number[0], present_cylinder_number[1], present_cylinder_number[2], present_cylinder_number[3], a, b, 8'h02, 8'hBF, c & 8'h7F, c};
        send('{8'h0E});
        drain("dump");
        final_report();
    end
endmodule
